/* shared/pixel_fwd_cfg.svh */
// Constants for the dual video pixel forwarder
`ifndef PIXEL_FWD_CFG_SVH
`define PIXEL_FWD_CFG_SVH
`define CORE_CLK_HZ        20000000
`define LONG_PRESS_MS      3000
`define SHORT_PRESS_MS     20
`define RX_BUS_W           36
`define LANE_W             10
`define OUT_W              30
`define BLUE_LSB           0
`define GREEN_LSB          10
`define RED_LSB            20
`define PAD_8BIT           2'h0
`define FIFO_DEPTH         16
`define FIFO_AW            4
`define SEL_W              8
`define ROT_W              4
`endif

/* shared/pixel_fwd_pkg.sv */
// Types shared by the pixel forwarder files
package pixel_fwd_pkg;
    // One forwarded pixel with its timing flags
    typedef struct packed {
        logic        vsync;
        logic        hsync;
        logic        data_valid;
        logic [29:0] rgb;
    } pixel_word_t;

    // Receiver output format choices
    typedef enum logic [1:0] {
        FMT_RGB10_LOW  = 2'h0,
        FMT_RGB10_HIGH = 2'h1,
        FMT_RGB8_LOW   = 2'h2,
        FMT_RGB8_HIGH  = 2'h3
    } rx_format_t;

    // Reset button states, one-hot
    typedef enum logic [3:0] {
        BTN_IDLE    = 4'h1,
        BTN_HELD    = 4'h2,
        BTN_LONG    = 4'h4,
        BTN_RELEASE = 4'h8
    } btn_state_t;
endpackage : pixel_fwd_pkg

/* rtl/pixel_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "pixel_fwd_cfg.svh"
module pixel_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Honest full and empty from the occupancy count
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    // Storage array
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    // Pointers and count
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + AW'(1);
            if (pop)
                rd_ptr_r <= rd_ptr_r + AW'(1);
            if (push && !pop)
                count_r <= count_r + (AW+1)'(1);
            else if (pop && !push)
                count_r <= count_r - (AW+1)'(1);
        end
    end
endmodule : pixel_fifo

/* rtl/dual_video_pixel_forwarder.sv */
// Two-channel pixel forwarder from receiver buses to connector outputs
`timescale 1ns/1ps
`include "pixel_fwd_cfg.svh"
module dual_video_pixel_forwarder #(
    parameter int LONG_PRESS_CYCLES  = `CORE_CLK_HZ / 1000 * `LONG_PRESS_MS,
    parameter int SHORT_PRESS_CYCLES = `CORE_CLK_HZ / 1000 * `SHORT_PRESS_MS
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic [1:0]             chan_pixel_clock,
    input  wire logic [1:0][35:0]       chan_pixel_bus,
    input  wire logic [1:0]             chan_data_valid,
    input  wire logic [1:0]             chan_hsync,
    input  wire logic [1:0]             chan_vsync,
    input  wire pixel_fwd_pkg::rx_format_t chan_format,
    input  wire logic                   reset_push_button_n,
    input  wire logic                   rom_source_select_switch,
    input  wire logic [7:0]             dip_switch_bank,
    input  wire logic [3:0]             rotary_selector,
    output logic [1:0]                  fwd_pixel_clock,
    output pixel_fwd_pkg::pixel_word_t  fwd_pixel_0,
    output pixel_fwd_pkg::pixel_word_t  fwd_pixel_1,
    output logic [1:0]                  fifo_overflow,
    output logic [7:0]                  rom_image_select,
    output logic                        logic_reset_pulse,
    output logic                        reconfig_request
);
    // ------------------------------------------------------------------
    // Button and switch inputs
    // ------------------------------------------------------------------
    logic [2:0]  btn_sync_r;
    logic        sel_meta_r;
    logic        sel_sync_r;
    logic [7:0]  dip_meta_r;
    logic [7:0]  dip_sync_r;
    logic [3:0]  rot_meta_r;
    logic [3:0]  rot_sync_r;
    logic [31:0] press_cnt_r;
    pixel_fwd_pkg::btn_state_t btn_state_r;

    // Two-stage synchronisers, three stages for the button; the first stage feeds only the second
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            btn_sync_r <= 3'h7;
            sel_meta_r <= 1'h0;
            sel_sync_r <= 1'h0;
            dip_meta_r <= 8'h00;
            dip_sync_r <= 8'h00;
            rot_meta_r <= 4'h0;
            rot_sync_r <= 4'h0;
        end
        else
        begin
            btn_sync_r <= {btn_sync_r[1:0], reset_push_button_n};
            sel_meta_r <= rom_source_select_switch;
            sel_sync_r <= sel_meta_r;
            dip_meta_r <= dip_switch_bank;
            dip_sync_r <= dip_meta_r;
            rot_meta_r <= rotary_selector;
            rot_sync_r <= rot_meta_r;
        end
    end

    // ROM image choice; the rotary source is zero-extended to the DIP width
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            rom_image_select <= 8'h00;
        else if (sel_sync_r)
            rom_image_select <= dip_sync_r;
        else
            rom_image_select <= {4'h0, rot_sync_r};
    end

    // Press timing: a short press resets, a long hold reconfigures.
    // Short glitches below the debounce time are ignored as bounce.
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            btn_state_r       <= pixel_fwd_pkg::BTN_IDLE;
            press_cnt_r       <= 32'h0;
            logic_reset_pulse <= 1'h0;
            reconfig_request  <= 1'h0;
        end
        else
        begin
            logic_reset_pulse <= 1'h0;
            reconfig_request  <= 1'h0;
            case (btn_state_r)
                pixel_fwd_pkg::BTN_IDLE:
                begin
                    press_cnt_r <= 32'h0;
                    if (!btn_sync_r[2])
                        btn_state_r <= pixel_fwd_pkg::BTN_HELD;
                end
                pixel_fwd_pkg::BTN_HELD:
                begin
                    if (btn_sync_r[2])
                    begin
                        btn_state_r <= pixel_fwd_pkg::BTN_IDLE;
                        if (press_cnt_r >= 32'(SHORT_PRESS_CYCLES))
                            logic_reset_pulse <= 1'h1;
                    end
                    else if (press_cnt_r >= 32'(LONG_PRESS_CYCLES - 1))
                    begin
                        btn_state_r      <= pixel_fwd_pkg::BTN_LONG;
                        reconfig_request <= 1'h1;
                    end
                    else
                        press_cnt_r <= press_cnt_r + 32'h1;
                end
                pixel_fwd_pkg::BTN_LONG:
                begin
                    if (btn_sync_r[2])
                        btn_state_r <= pixel_fwd_pkg::BTN_RELEASE;
                end
                pixel_fwd_pkg::BTN_RELEASE:
                    btn_state_r <= pixel_fwd_pkg::BTN_IDLE;
                default:
                    btn_state_r <= pixel_fwd_pkg::BTN_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Per-channel pixel path
    // ------------------------------------------------------------------
    pixel_fwd_pkg::pixel_word_t out_word [2];

    assign fwd_pixel_0 = out_word[0];
    assign fwd_pixel_1 = out_word[1];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            logic [2:0]  clk_sync_r;
            logic [35:0] bus_meta_r;
            logic [35:0] bus_sync_r;
            logic [2:0]  ctl_meta_r;
            logic [2:0]  ctl_sync_r;
            logic        rise;
            logic        fall;
            logic [29:0] rgb_nxt;
            pixel_fwd_pkg::pixel_word_t in_word;
            pixel_fwd_pkg::pixel_word_t fifo_word;
            logic        fifo_in_ready;
            logic        fifo_valid;
            logic        fwd_clk_r;
            pixel_fwd_pkg::pixel_word_t word_r;
            logic        ovf_r;

            // Pixel clock is sampled; edges are read only past the first stage
            always_ff @(posedge core_clk)
            begin
                if (!reset_n)
                begin
                    clk_sync_r <= 3'h0;
                    bus_meta_r <= 36'h0;
                    bus_sync_r <= 36'h0;
                    ctl_meta_r <= 3'h0;
                    ctl_sync_r <= 3'h0;
                end
                else
                begin
                    clk_sync_r <= {clk_sync_r[1:0], chan_pixel_clock[ch]};
                    bus_meta_r <= chan_pixel_bus[ch];
                    bus_sync_r <= bus_meta_r;
                    ctl_meta_r <= {chan_vsync[ch], chan_hsync[ch], chan_data_valid[ch]};
                    ctl_sync_r <= ctl_meta_r;
                end
            end

            assign rise = clk_sync_r[1] && !clk_sync_r[2];
            assign fall = !clk_sync_r[1] && clk_sync_r[2];

            // Lane extraction by format; each 12-bit receiver group keeps its low or top bits as the format selects
            always_comb
            begin
                case (chan_format)
                    pixel_fwd_pkg::FMT_RGB10_LOW:
                        rgb_nxt = {bus_sync_r[33:24], bus_sync_r[21:12], bus_sync_r[9:0]};
                    pixel_fwd_pkg::FMT_RGB10_HIGH:
                        rgb_nxt = {bus_sync_r[35:26], bus_sync_r[23:14], bus_sync_r[11:2]};
                    pixel_fwd_pkg::FMT_RGB8_LOW:
                        rgb_nxt = {bus_sync_r[31:24], `PAD_8BIT, bus_sync_r[19:12],
                                   `PAD_8BIT, bus_sync_r[7:0], `PAD_8BIT};
                    pixel_fwd_pkg::FMT_RGB8_HIGH:
                        rgb_nxt = {bus_sync_r[35:28], `PAD_8BIT, bus_sync_r[23:16],
                                   `PAD_8BIT, bus_sync_r[11:4], `PAD_8BIT};
                    default:
                        rgb_nxt = 30'h0;
                endcase
            end

            // Pixel, syncs and valid travel together as one word
            assign in_word.vsync      = ctl_sync_r[2];
            assign in_word.hsync      = ctl_sync_r[1];
            assign in_word.data_valid = ctl_sync_r[0];
            assign in_word.rgb        = rgb_nxt;

            // Captured on the rising pixel edge, drained on the falling one
            pixel_fifo #(
                .WIDTH ($bits(pixel_fwd_pkg::pixel_word_t)),
                .DEPTH (`FIFO_DEPTH),
                .AW    (`FIFO_AW)
            ) u_fifo (
                .core_clk  (core_clk),
                .reset_n   (reset_n),
                .in_valid  (rise),
                .in_ready  (fifo_in_ready),
                .in_data   (in_word),
                .out_valid (fifo_valid),
                .out_ready (fall),
                .out_data  (fifo_word)
            );

            // Forwarded clock follows the second sync stage, so it falls on the very
            // edge that loads a new word; a later stage would change data while high
            always_ff @(posedge core_clk)
            begin
                if (!reset_n)
                begin
                    fwd_clk_r <= 1'h0;
                    word_r    <= '0;
                    ovf_r     <= 1'h0;
                end
                else
                begin
                    fwd_clk_r <= clk_sync_r[1];
                    if (fall && fifo_valid)
                        word_r <= fifo_word;
                    if (rise && !fifo_in_ready)
                        ovf_r <= 1'h1;
                end
            end

            assign fwd_pixel_clock[ch] = fwd_clk_r;
            assign out_word[ch]        = word_r;
            assign fifo_overflow[ch]   = ovf_r;
        end
    endgenerate
endmodule : dual_video_pixel_forwarder

/* testbench/pixel_fwd_props.sv */
// Port-level checker for the dual video pixel forwarder
`timescale 1ns/1ps
module pixel_fwd_props #(
    parameter int LONG_PRESS_CYCLES  = 50,
    parameter int SHORT_PRESS_CYCLES = 5
) (
    input wire logic                       core_clk,
    input wire logic                       reset_n,
    input wire logic [1:0]                 chan_pixel_clock,
    input wire pixel_fwd_pkg::rx_format_t  chan_format,
    input wire logic                       reset_push_button_n,
    input wire logic                       rom_source_select_switch,
    input wire logic [7:0]                 dip_switch_bank,
    input wire logic [3:0]                 rotary_selector,
    input wire logic [1:0]                 fwd_pixel_clock,
    input wire pixel_fwd_pkg::pixel_word_t fwd_pixel_0,
    input wire pixel_fwd_pkg::pixel_word_t fwd_pixel_1,
    input wire logic [7:0]                 rom_image_select,
    input wire logic                       logic_reset_pulse,
    input wire logic                       reconfig_request
);
    logic [3:0] quiet_r;
    int         held_r;
    int         last_hold_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Cycles since any reset; the button's own reset may clear outputs meanwhile
    always_ff @(posedge core_clk)
        if (!reset_n || logic_reset_pulse) quiet_r <= 4'h0;
        else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
    // Length of the current button hold
    always_ff @(posedge core_clk)
        if (!reset_n || reset_push_button_n) held_r <= 0;
        else held_r <= held_r + 1;
    // Length of the hold that has just ended, kept until the next release
    always_ff @(posedge core_clk)
        if (!reset_n) last_hold_r <= 0;
        else if (reset_push_button_n && held_r != 0) last_hold_r <= held_r;
    AST_PAD_ZERO: assert property (
        chan_format[1] |-> ((fwd_pixel_0.rgb | fwd_pixel_1.rgb) & 30'h00300C03) == 30'h0)
        else $error("low lane bits set in 8-bit format");
    AST_LAUNCH_FALL0: assert property (
        quiet_r > 4'h8 && $changed(fwd_pixel_0) |-> $fell(fwd_pixel_clock[0]))
        else $error("channel 0 word changed off the falling clock");
    AST_LAUNCH_FALL1: assert property (
        quiet_r > 4'h8 && $changed(fwd_pixel_1) |-> $fell(fwd_pixel_clock[1]))
        else $error("channel 1 word changed off the falling clock");
    AST_CLOCK_FWD: assert property (
        quiet_r > 4'h4 |-> fwd_pixel_clock == $past(chan_pixel_clock, 3))
        else $error("forwarded clock not three cycles behind its pin");
    AST_CFG_PULSE: assert property (
        reconfig_request |=> !reconfig_request)
        else $error("reconfiguration request longer than one cycle");
    AST_CFG_HOLD: assert property (
        reconfig_request |-> held_r >= LONG_PRESS_CYCLES && held_r <= LONG_PRESS_CYCLES + 8)
        else $error("reconfiguration request without a full hold");
    AST_RST_PULSE: assert property (
        logic_reset_pulse |-> reset_push_button_n ##1 !logic_reset_pulse)
        else $error("logic reset pulse while held or too long");
    AST_RST_HOLD: assert property (
        logic_reset_pulse |-> last_hold_r >= SHORT_PRESS_CYCLES)
        else $error("logic reset pulse after a press shorter than debounce");
    AST_ROM_SEL: assert property (
        (quiet_r > 4'h8 && $stable({rom_source_select_switch, dip_switch_bank,
        rotary_selector}))[*6] |-> rom_image_select == (rom_source_select_switch ?
        dip_switch_bank : {4'h0, rotary_selector}))
        else $error("image select does not follow the chosen switch");
    cover property (reconfig_request);
    cover property (logic_reset_pulse);
    cover property ($fell(fwd_pixel_clock[1]) && $changed(fwd_pixel_1));
endmodule : pixel_fwd_props

bind dual_video_pixel_forwarder pixel_fwd_props #(
    .LONG_PRESS_CYCLES(LONG_PRESS_CYCLES),
    .SHORT_PRESS_CYCLES(SHORT_PRESS_CYCLES)
) u_props (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .chan_pixel_clock(chan_pixel_clock),
    .chan_format(chan_format),
    .reset_push_button_n(reset_push_button_n),
    .rom_source_select_switch(rom_source_select_switch),
    .dip_switch_bank(dip_switch_bank),
    .rotary_selector(rotary_selector),
    .fwd_pixel_clock(fwd_pixel_clock),
    .fwd_pixel_0(fwd_pixel_0),
    .fwd_pixel_1(fwd_pixel_1),
    .rom_image_select(rom_image_select),
    .logic_reset_pulse(logic_reset_pulse),
    .reconfig_request(reconfig_request)
);

/* testbench/carrier_sink.sv */
// Carrier-side capture model for one forwarded pixel channel
`timescale 1ns/1ps
module carrier_sink (
    input wire logic                       pix_clk,
    input wire logic                       reset_n,
    input wire pixel_fwd_pkg::pixel_word_t word
);
    pixel_fwd_pkg::pixel_word_t got[$];
    pixel_fwd_pkg::pixel_word_t last_r = '0;
    // Latch on the rising clock; a word standing over idle periods counts once
    always @(posedge pix_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            got.delete();
            last_r = '0;
        end
        else if (word !== last_r)
        begin
            got.push_back(word);
            last_r = word;
        end
    end
endmodule : carrier_sink

/* testbench/tb.sv */
// Self-checking bench for the dual video pixel forwarder
`timescale 1ns/1ps
module tb;
    localparam int LONG_C = 50;
    logic                       core_clk = 1'b0;
    logic                       reset_n = 1'b0;
    logic [1:0]                 pclk = 2'h0, pde = 2'h0, phs = 2'h0, pvs = 2'h0;
    logic [1:0][35:0]           pbus = 72'h0;
    pixel_fwd_pkg::rx_format_t  fmt = pixel_fwd_pkg::FMT_RGB10_LOW;
    logic                       btn_n = 1'b1, src_sw = 1'b0, rst_pulse, reconf;
    logic [7:0]                 dip = 8'h00, rom_sel;
    logic [3:0]                 rot = 4'h0;
    logic [1:0]                 fclk, ovf;
    pixel_fwd_pkg::pixel_word_t fw0, fw1, exp0[$], exp1[$];
    int                         n_errors = 0, checks_done = 0, cycles = 0;
    logic [31:0]                seed = 32'h00007E81;
    dual_video_pixel_forwarder #(.LONG_PRESS_CYCLES(LONG_C), .SHORT_PRESS_CYCLES(5)) uut (
        .core_clk(core_clk), .reset_n(reset_n), .chan_pixel_clock(pclk),
        .chan_pixel_bus(pbus), .chan_data_valid(pde), .chan_hsync(phs), .chan_vsync(pvs),
        .chan_format(fmt), .reset_push_button_n(btn_n), .rom_source_select_switch(src_sw),
        .dip_switch_bank(dip), .rotary_selector(rot), .fwd_pixel_clock(fclk),
        .fwd_pixel_0(fw0), .fwd_pixel_1(fw1), .fifo_overflow(ovf), .rom_image_select(rom_sel),
        .logic_reset_pulse(rst_pulse), .reconfig_request(reconf));
    carrier_sink cap0 (.pix_clk(fclk[0]), .reset_n(reset_n), .word(fw0));
    carrier_sink cap1 (.pix_clk(fclk[1]), .reset_n(reset_n), .word(fw1));
    // Free-running core clock and a hang guard well above the expected run
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_errors++;
            test_done();
        end
    end
    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // One 10-bit lane out of a 12-bit source group
    function automatic logic [9:0] lane(input logic [11:0] g);
        case (fmt)
            2'h0: lane = g[9:0];
            2'h1: lane = g[11:2];
            2'h2: lane = {g[7:0], 2'h0};
            default: lane = {g[11:4], 2'h0};
        endcase
    endfunction : lane
    function automatic pixel_fwd_pkg::pixel_word_t exp_word(input logic [38:0] r);
        exp_word = {r[38:36], lane(r[35:24]), lane(r[23:12]), lane(r[11:0])};
    endfunction : exp_word
    task automatic check(input logic [32:0] seen, input logic [32:0] want, input string what);
        checks_done++;
        if (seen !== want)
        begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check
    // Format only changes while reset is held, as it is static in use
    task automatic do_reset(input logic [1:0] f);
        @(posedge core_clk);
        reset_n <= 1'b0;
        fmt <= pixel_fwd_pkg::rx_format_t'(f);
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask : do_reset
    // Pixel clock runs only within a burst; one spare period flushes the last word
    task automatic burst(input int n);
        logic [63:0] r;
        for (int k = 0; k <= n; k++)
        begin
            @(posedge core_clk);
            pclk <= 2'h0;
            for (int c = 0; c < 2; c++)
            begin
                r = {rnd(), rnd()};
                pbus[c] <= r[35:0];
                {pvs[c], phs[c], pde[c]} <= r[38:36];
                if (k < n && c == 0) exp0.push_back(exp_word(r[38:0]));
                if (k < n && c == 1) exp1.push_back(exp_word(r[38:0]));
            end
            repeat (4) @(posedge core_clk);
            pclk <= 2'h3;
            repeat (3) @(posedge core_clk);
        end
        @(posedge core_clk);
        pclk <= 2'h0;
        repeat (30) @(posedge core_clk);
    endtask : burst
    task automatic press(input int n, input logic want_rst, input logic want_cfg);
        logic seen_rst = 1'b0;
        logic seen_cfg = 1'b0;
        @(posedge core_clk);
        btn_n <= 1'b0;
        for (int i = 0; i < n + 20; i++)
        begin
            @(posedge core_clk);
            if (i == n) btn_n <= 1'b1;
            seen_rst |= rst_pulse;
            seen_cfg |= reconf;
        end
        check(33'(seen_rst), 33'(want_rst), "logic reset pulse");
        check(33'(seen_cfg), 33'(want_cfg), "reconfiguration request");
    endtask : press
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial
    begin
        for (int f = 0; f < 4; f++)
        begin
            do_reset(f[1:0]);
            burst(8);
            check(33'(cap0.got.size()), 33'(8), "channel 0 count");
            check(33'(cap1.got.size()), 33'(8), "channel 1 count");
            foreach (exp0[i])
            begin
                check(cap0.got[i], exp0[i], "channel 0 word");
                check(cap1.got[i], exp1[i], "channel 1 word");
            end
            check(33'(ovf), 33'(0), "overflow flag");
            exp0.delete();
            exp1.delete();
            $display("format %0d test done", f);
        end
        // Alternate the source switch; the first pass rests the rotary at zero
        for (int i = 0; i < 6; i++)
        begin
            logic [31:0] r;
            r = rnd();
            if (i == 0) r[11:8] = 4'h0;
            @(posedge core_clk);
            src_sw <= i[0];
            dip <= r[7:0];
            rot <= r[11:8];
            repeat (7) @(posedge core_clk);
            check(33'(rom_sel), 33'(i[0] ? r[7:0] : {4'h0, r[11:8]}), "image select");
        end
        $display("image select test done");
        press(2, 1'b0, 1'b0);
        press(10, 1'b1, 1'b0);
        press(LONG_C + 30, 1'b0, 1'b1);
        $display("button test done");
        test_done();
    end
endmodule : tb
